// ### mft_pkg.sv
package mft_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_CNT1 = 6'h00;
  localparam logic [5:0] OFS_CRA = 6'h04;
  localparam logic [5:0] OFS_CRB = 6'h08;
  localparam logic [5:0] OFS_CNT2 = 6'h0c;
  localparam logic [5:0] OFS_PRSC = 6'h10;
  localparam logic [5:0] OFS_CKC = 6'h14;
  localparam logic [5:0] OFS_MCTRL = 6'h18;
  localparam logic [5:0] OFS_ICTRL = 6'h1c;
  localparam logic [5:0] OFS_ICLR = 6'h20;

  localparam logic [31:0] BASE_FIRST = 32'h40d00000;
  localparam logic [31:0] BASE_SECOND = 32'h40e00000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  // mode control
  localparam int MC_MODE_LO = 0;
  localparam int MC_EN = 3;
  localparam int MC_AEN = 4;
  localparam int MC_BEN = 5;
  localparam int MC_AEDG = 6;
  localparam int MC_BEDG = 7;
  localparam int MC_AOUT = 8;
  localparam int MC_PTSE = 9;
  // interrupt control: enables in 3:0, pending in 7:4
  localparam int IC_EN_LO = 0;
  localparam int IC_PND_LO = 4;
  // clock unit control: clock select fields
  localparam int CK_C1_LO = 0;
  localparam int CK_C2_LO = 3;

  localparam logic [15:0] CNT_PRESET = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MD_OFF = 3'h0,
    MD_PWM = 3'h1,
    MD_CAP2 = 3'h3,
    MD_DUAL = 3'h2,
    MD_CAPT = 3'h6,
    MD_TRAIN = 3'h7
  } mft_mode_t;

  // clock select: 0 stopped, 1 prescaled, 3 external event on secondary pin
  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_PRSC = 3'h1,
    CS_EVENT = 3'h3
  } mft_clk_sel_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } mft_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mft_wb_rsp_t;

endpackage

// ### mft_timer.sv
// Functional notes
// - each instance has exactly two pins, primary and secondary, roles set by mode.
// - modes 1, 1a, 3 and 4 with primary enable toggle primary pin on counter one underflow.
// - output level bit sets start level and current level of the waveform output.
// - mode 2 primary edge captures counter one into A; enable also presets it.
// - modes 1 and 3 use secondary pin as external event input regardless of enables.
// - mode 2 with secondary enable clear: secondary edge captures counter one into B.
// - mode 4 secondary edge captures counter two into B; enable then presets it.
// - in capture operation counting waits for the first selected pin event.
// - four interrupt sources A to D, each with pending flag and enable bit.
// - A, B, C drive first interrupt output; D alone drives the second.
// - flag A on reload from A in modes 1, 1a, 3, 4; on primary capture in 2.
// - flag B on reload from B in 1, 1a; on secondary capture in 2, 4; never in 3.
// - flag C only in mode 2, set on counter one underflow whatever its enable.
// - flag D on counter two underflow in 1, 1a, 2, 4; on reload from B in 3.
// - two instances at distinct bases, nine word registers from 0x00 to 0x20.
// - counter one in bits 15:0, not reset, reads live count, upper half reserved.
// - writes to counter one are discarded while module enable is 0.
// - capture registers always readable; writes dropped while module enable is 0.
`timescale 1ns/1ns
module mft_timer
  import mft_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = BASE_FIRST
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register bus
  input wire mft_wb_req_t wb_req,
  output mft_wb_rsp_t wb_rsp,
  // timer pins
  input wire logic primary_timer_pin_in,
  output logic primary_timer_pin_out,
  output logic primary_timer_pin_oe,
  input wire logic secondary_timer_pin_in,
  // interrupts
  output logic irq_one,
  output logic irq_two
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [15:0] counter_one_reg;
  logic [15:0] counter_two_reg;
  logic [15:0] capture_a_reg;
  logic [15:0] capture_b_reg;
  logic [7:0] prescaler_reg;
  logic [5:0] clock_ctrl_reg;
  logic [9:0] mode_ctrl_reg;
  logic [3:0] irq_enable_reg;
  logic [3:0] pending_reg;
  logic [7:0] presc_cnt_reg;
  logic pin_level_reg;
  logic armed_one_reg;
  logic armed_two_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  mft_mode_t mode;
  logic module_en;
  logic primary_en;
  logic secondary_en;
  assign mode = mft_mode_t'(mode_ctrl_reg[MC_MODE_LO +: 3]);
  assign module_en = mode_ctrl_reg[MC_EN];
  assign primary_en = mode_ctrl_reg[MC_AEN];
  assign secondary_en = mode_ctrl_reg[MC_BEN];

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic bus_hit;
  logic wr_stb;
  logic [5:0] ofs;
  assign ofs = wb_req.adr[5:0];
  assign bus_hit = wb_req.adr[31:6] == BASE_ADDR[31:6];
  // write takes effect on the edge where ack is presented
  assign wr_stb = wb_req.cyc && wb_req.stb && wb_req.we && ack_reg && wb_req.sel[0];
  logic wr_cnt1;
  logic wr_cra;
  logic wr_crb;
  logic wr_cnt2;
  assign wr_cnt1 = wr_stb && bus_hit && ofs == OFS_CNT1 && module_en;
  assign wr_cra = wr_stb && bus_hit && ofs == OFS_CRA && module_en;
  assign wr_crb = wr_stb && bus_hit && ofs == OFS_CRB && module_en;
  assign wr_cnt2 = wr_stb && bus_hit && ofs == OFS_CNT2 && module_en;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [1:0] a_sync_reg;
  logic [1:0] b_sync_reg;
  logic a_last_reg;
  logic b_last_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_sync_reg <= 2'h0;
      b_sync_reg <= 2'h0;
      a_last_reg <= 1'b0;
      b_last_reg <= 1'b0;
    end else begin
      a_sync_reg <= {a_sync_reg[0], primary_timer_pin_in};
      b_sync_reg <= {b_sync_reg[0], secondary_timer_pin_in};
      a_last_reg <= a_sync_reg[1];
      b_last_reg <= b_sync_reg[1];
    end
  end

  // edge bit 0 selects rising, 1 falling; pulses shorter than a cycle may be missed
  logic a_edge;
  logic b_edge;
  assign a_edge = mode_ctrl_reg[MC_AEDG] ? (a_last_reg && !a_sync_reg[1])
                                         : (!a_last_reg && a_sync_reg[1]);
  assign b_edge = mode_ctrl_reg[MC_BEDG] ? (b_last_reg && !b_sync_reg[1])
                                         : (!b_last_reg && b_sync_reg[1]);

  // ---------------------------------------------------------------
  // pin roles per mode
  // ---------------------------------------------------------------
  logic a_capture;
  logic b_cap_one;
  logic b_cap_two;
  logic b_is_event;
  assign a_capture = module_en && mode == MD_CAP2 && a_edge;
  // enabled secondary in mode 2 behaves as a second primary trigger
  assign b_cap_one = module_en && mode == MD_CAP2 && b_edge;
  assign b_cap_two = module_en && mode == MD_CAPT && b_edge;
  assign b_is_event = (mode == MD_PWM || mode == MD_DUAL ||
                       (mode == MD_TRAIN && !mode_ctrl_reg[MC_PTSE])) && b_edge;

  // ---------------------------------------------------------------
  // clock ticks
  // ---------------------------------------------------------------
  logic presc_tick;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt_reg <= 8'h00;
    end else if (presc_cnt_reg == 8'h00) begin
      presc_cnt_reg <= prescaler_reg;
    end else begin
      presc_cnt_reg <= presc_cnt_reg - 8'h01;
    end
  end
  assign presc_tick = module_en && presc_cnt_reg == 8'h00;

  function automatic logic sel_tick(input logic [2:0] sel, input logic ptick, input logic evt);
    case (sel)
      CS_PRSC: sel_tick = ptick;
      CS_EVENT: sel_tick = evt;
      default: sel_tick = 1'b0;
    endcase
  endfunction

  logic tick_one;
  logic tick_two;
  // a counter whose pin is a capture input cannot count events: it stops
  assign tick_one = module_en && armed_one_reg && !(mode == MD_CAP2 && clock_ctrl_reg[CK_C1_LO +: 3] == CS_EVENT)
                    && sel_tick(clock_ctrl_reg[CK_C1_LO +: 3], presc_tick, b_is_event);
  assign tick_two = module_en && armed_two_reg && !(mode == MD_CAPT && clock_ctrl_reg[CK_C2_LO +: 3] == CS_EVENT)
                    && sel_tick(clock_ctrl_reg[CK_C2_LO +: 3], presc_tick, b_is_event);

  logic under_one;
  logic under_two;
  assign under_one = tick_one && counter_one_reg == CNT_ZERO;
  assign under_two = tick_two && counter_two_reg == CNT_ZERO;

  // ---------------------------------------------------------------
  // capture arming: counting held until first pin event
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_one_reg <= 1'b0;
      armed_two_reg <= 1'b0;
    end else if (!module_en) begin
      armed_one_reg <= 1'b0;
      armed_two_reg <= 1'b0;
    end else begin
      if (mode != MD_CAP2 || a_capture || b_cap_one) begin
        armed_one_reg <= 1'b1;
      end
      if (mode != MD_CAPT || b_cap_two) begin
        armed_two_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // counter one and its reload alternation
  // ---------------------------------------------------------------
  logic reload_b_phase_reg;
  logic reload_one_a;
  logic reload_one_b;
  logic alt_reload;
  // modes 1 and 1a alternate reload between A and B for the waveform
  assign alt_reload = mode == MD_PWM || mode == MD_TRAIN;
  assign reload_one_a = under_one && (mode == MD_DUAL || mode == MD_CAPT ||
                                      (alt_reload && !reload_b_phase_reg));
  assign reload_one_b = under_one && alt_reload && reload_b_phase_reg;

  // counters carry no reset: contents are undefined until software loads them
  always_ff @(posedge core_clk) begin
    if (wr_cnt1) begin
      counter_one_reg <= wb_req.dat[15:0];
    end else if (a_capture && primary_en) begin
      counter_one_reg <= CNT_PRESET;
    end else if (b_cap_one && secondary_en) begin
      counter_one_reg <= CNT_PRESET;
    end else if (reload_one_a) begin
      counter_one_reg <= capture_a_reg;
    end else if (reload_one_b) begin
      counter_one_reg <= capture_b_reg;
    end else if (tick_one) begin
      counter_one_reg <= counter_one_reg - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_b_phase_reg <= 1'b0;
    end else if (!module_en || !alt_reload) begin
      reload_b_phase_reg <= 1'b0;
    end else if (under_one) begin
      reload_b_phase_reg <= !reload_b_phase_reg;
    end
  end

  // ---------------------------------------------------------------
  // counter two
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (wr_cnt2) begin
      counter_two_reg <= wb_req.dat[15:0];
    end else if (b_cap_two && secondary_en) begin
      counter_two_reg <= CNT_PRESET;
    end else if (under_two && mode == MD_DUAL) begin
      counter_two_reg <= capture_b_reg;
    end else if (tick_two) begin
      counter_two_reg <= counter_two_reg - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // capture registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (a_capture || (b_cap_one && secondary_en)) begin
      capture_a_reg <= counter_one_reg;
    end else if (wr_cra) begin
      capture_a_reg <= wb_req.dat[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (b_cap_one && !secondary_en) begin
      capture_b_reg <= counter_one_reg;
    end else if (b_cap_two) begin
      capture_b_reg <= counter_two_reg;
    end else if (wr_crb) begin
      capture_b_reg <= wb_req.dat[15:0];
    end
  end

  // ---------------------------------------------------------------
  // primary pin waveform
  // ---------------------------------------------------------------
  logic wave_mode;
  assign wave_mode = primary_en && (mode == MD_PWM || mode == MD_TRAIN || mode == MD_CAPT || mode == MD_DUAL);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level_reg <= 1'b0;
    end else if (wr_stb && bus_hit && ofs == OFS_MCTRL) begin
      pin_level_reg <= wb_req.dat[MC_AOUT];
    end else if (wave_mode && under_one) begin
      pin_level_reg <= !pin_level_reg;
    end
  end
  assign primary_timer_pin_out = pin_level_reg;
  assign primary_timer_pin_oe = wave_mode;

  // ---------------------------------------------------------------
  // interrupt pending flags: set wins over clear
  // ---------------------------------------------------------------
  logic [3:0] set_evt;
  logic [3:0] clr_evt;
  always_comb begin
    set_evt = 4'h0;
    set_evt[0] = (mode == MD_CAP2) ? (a_capture || (b_cap_one && secondary_en)) : reload_one_a;
    set_evt[1] = (mode == MD_CAP2) ? (b_cap_one && !secondary_en) :
                 (mode == MD_CAPT) ? b_cap_two : reload_one_b;
    set_evt[2] = mode == MD_CAP2 && under_one;
    set_evt[3] = under_two && mode != MD_OFF;
  end
  assign clr_evt = (wr_stb && bus_hit && ofs == OFS_ICLR) ? wb_req.dat[3:0] : 4'h0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 4'h0;
    end else begin
      pending_reg <= set_evt | (pending_reg & ~clr_evt);
    end
  end

  assign irq_one = |(pending_reg[2:0] & irq_enable_reg[2:0]);
  assign irq_two = pending_reg[3] & irq_enable_reg[3];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_reg <= 8'h00;
      clock_ctrl_reg <= 6'h00;
      mode_ctrl_reg <= 10'h000;
      irq_enable_reg <= 4'h0;
    end else if (wr_stb && bus_hit) begin
      case (ofs)
        OFS_PRSC: prescaler_reg <= wb_req.dat[7:0];
        OFS_CKC: clock_ctrl_reg <= wb_req.dat[5:0];
        OFS_MCTRL: mode_ctrl_reg <= wb_req.dat[9:0];
        OFS_ICTRL: irq_enable_reg <= wb_req.dat[IC_EN_LO +: 4];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bus answer: ack one cycle after request, dropped after one cycle
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = REG_RESET;
    case (ofs)
      OFS_CNT1: rd_mux = {16'h0000, counter_one_reg};
      OFS_CRA: rd_mux = {16'h0000, capture_a_reg};
      OFS_CRB: rd_mux = {16'h0000, capture_b_reg};
      OFS_CNT2: rd_mux = {16'h0000, counter_two_reg};
      OFS_PRSC: rd_mux = {24'h000000, prescaler_reg};
      OFS_CKC: rd_mux = {26'h0, clock_ctrl_reg};
      OFS_MCTRL: rd_mux = {22'h0, mode_ctrl_reg[9:9], pin_level_reg, mode_ctrl_reg[7:0]};
      OFS_ICTRL: rd_mux = {24'h000000, pending_reg, irq_enable_reg};
      default: rd_mux = REG_RESET;
    endcase
    if (!bus_hit) begin
      rd_mux = REG_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= REG_RESET;
    end else begin
      ack_reg <= wb_req.cyc && wb_req.stb && !ack_reg;
      rdata_reg <= rd_mux;
    end
  end

  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rdata_reg;

endmodule

// ### mft_monitor.sv
`timescale 1ns/1ns
module mft_monitor
  import mft_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = BASE_FIRST
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register bus
  input wire mft_wb_req_t wb_req,
  input wire mft_wb_rsp_t wb_rsp,
  // pins and interrupts
  input wire logic primary_timer_pin_in,
  input wire logic primary_timer_pin_out,
  input wire logic primary_timer_pin_oe,
  input wire logic secondary_timer_pin_in,
  input wire logic irq_one,
  input wire logic irq_two
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // shadows of mode control and interrupt enables
  // ------------------------------------------------------------
  logic hit;
  logic wr_hit;
  logic mc_wr;
  logic [31:0] mc_reg;
  logic [3:0] ien_reg;
  assign hit = wb_rsp.ack && wb_req.cyc && wb_req.stb && wb_req.adr[31:6] == BASE_ADDR[31:6];
  assign wr_hit = hit && wb_req.we && wb_req.sel[0];
  assign mc_wr = wr_hit && wb_req.adr[5:0] == OFS_MCTRL;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) mc_reg <= REG_RESET;
    else if (mc_wr) mc_reg <= wb_req.dat;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) ien_reg <= 4'h0;
    else if (wr_hit && wb_req.adr[5:0] == OFS_ICTRL) ien_reg <= wb_req.dat[3:0];
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_take;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  sequence s_level_load;
    mc_wr ##0 (wb_req.dat[MC_AEN] && wb_req.dat[2:0] != 3'h3 && wb_req.dat[2:0] != 3'h0);
  endsequence
  sequence s_pri_rise;
    $rose(primary_timer_pin_in) && mc_reg[2:0] == 3'h3 && mc_reg[MC_EN] && !mc_reg[MC_AEDG] && ien_reg[0];
  endsequence
  sequence s_irq_off;
    wr_hit ##0 (wb_req.adr[5:0] == OFS_ICTRL && wb_req.dat[3:0] == 4'h0);
  endsequence

  a_ack_latency: assert property (s_take |=> wb_rsp.ack)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");
  a_unmapped_zero: assert property (hit && !wb_req.we && wb_req.adr[5:0] > OFS_ICLR |-> wb_rsp.dat == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (hit && !wb_req.we && wb_req.adr[5:0] <= OFS_CNT2 |-> wb_rsp.dat[31:16] == 16'h0)
    else $error("reserved upper half of a count read not zero");
  a_level_load: assert property (s_level_load |=> primary_timer_pin_out == $past(wb_req.dat[MC_AOUT]))
    else $error("output level bit not loaded onto primary pin");
  a_pin_steady: assert property ($changed(primary_timer_pin_out) |->
      $past(mc_wr) || (mc_reg[MC_AEN] && mc_reg[2:0] != 3'h3 && mc_reg[2:0] != 3'h0))
    else $error("primary pin moved without waveform enable");
  a_oe_waveform: assert property (primary_timer_pin_oe |-> mc_reg[MC_AEN] && mc_reg[2:0] != 3'h3)
    else $error("primary pin driven outside waveform use");
  a_irq_off: assert property (s_irq_off |=> !irq_one && !irq_two)
    else $error("interrupt remains with all enables clear");
  a_capture_irq: assert property (s_pri_rise |-> ##[1:4] irq_one)
    else $error("primary capture edge raised no first interrupt");
  a_irq_one_gate: assert property (irq_one |-> ien_reg[2:0] != 3'h0)
    else $error("first interrupt without an enabled source");
  a_irq_two_gate: assert property (irq_two |-> ien_reg[3])
    else $error("second interrupt without its enable");
endmodule

bind mft_timer mft_monitor #(.BASE_ADDR(BASE_ADDR)) mft_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .primary_timer_pin_in(primary_timer_pin_in),
  .primary_timer_pin_out(primary_timer_pin_out), .primary_timer_pin_oe(primary_timer_pin_oe),
  .secondary_timer_pin_in(secondary_timer_pin_in), .irq_one(irq_one), .irq_two(irq_two));

// ### mft_pin_stub.sv
`timescale 1ns/1ns
module mft_pin_stub (
  input wire logic core_clk,
  output logic pri_drive = 1'b0,
  output logic sec_drive = 1'b0
);
  // one rising and one falling edge; both must not yield two events
  task automatic pulse(input bit sec);
    @(posedge core_clk);
    if (sec) sec_drive <= 1'b1;
    else pri_drive <= 1'b1;
    repeat (2) @(posedge core_clk);
    pri_drive <= 1'b0;
    sec_drive <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// ### test_mft_timer.sv
`timescale 1ns/1ns
module test_mft_timer;
  import mft_pkg::*;
  logic core_clk, rst_n, pin_out, pin_oe, pri_drive, sec_drive, pri_wire, irq_one, irq_two, lvl;
  mft_wb_req_t wb_req;
  mft_wb_rsp_t wb_rsp;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [3:0] sel_q = 4'hf;
  logic [31:0] base_q = BASE_FIRST;
  // the design's own level wins while it drives the shared pin
  assign pri_wire = pin_oe ? pin_out : pri_drive;

  mft_timer mft_timer_i (.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .primary_timer_pin_in(pri_wire), .primary_timer_pin_out(pin_out), .primary_timer_pin_oe(pin_oe),
    .secondary_timer_pin_in(sec_drive), .irq_one(irq_one), .irq_two(irq_two));
  mft_pin_stub mft_pin_stub_i (.core_clk(core_clk), .pri_drive(pri_drive), .sec_drive(sec_drive));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      results();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [5:0] ofs, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel_q, adr: base_q | 32'(ofs), dat: d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    if (n == 50) chk("bus_ack", 32'h1, 32'h0);
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task automatic rd(input logic [5:0] ofs, input string name, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0);
    chk(name, exp, q);
  endtask
  function automatic logic [31:0] mc(input mft_mode_t m, input logic a, input logic b, input logic o);
    return 32'(m) | (32'h1 << MC_EN) | (32'(a) << MC_AEN) | (32'(b) << MC_BEN) | (32'(o) << MC_AOUT);
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_map();
    rd(OFS_MCTRL, "mctrl_reset", 32'h0);
    rd(OFS_ICTRL, "ictrl_reset", 32'h0);
    rd(OFS_CKC, "ckc_reset", 32'h0);
    rd(OFS_PRSC, "prsc_reset", 32'h0);
    rd(6'h24, "unmapped", 32'h0);
    bus(1'b1, OFS_PRSC, 32'h000000ab);
    rd(OFS_PRSC, "prsc_rw", 32'h000000ab);
    sel_q = 4'he;
    bus(1'b1, OFS_PRSC, 32'h0);
    sel_q = 4'hf;
    base_q = BASE_SECOND;
    bus(1'b1, OFS_PRSC, 32'h0);
    rd(OFS_PRSC, "prsc_foreign", 32'h0);
    base_q = BASE_FIRST;
    rd(OFS_PRSC, "prsc_kept", 32'h000000ab);
    bus(1'b1, OFS_PRSC, 32'h0);
  endtask
  task automatic t_write_gate();
    bus(1'b1, OFS_MCTRL, mc(MD_DUAL, 1'b0, 1'b0, 1'b0));
    bus(1'b1, OFS_CNT1, 32'hffff00aa);
    bus(1'b1, OFS_CRA, 32'h1234);
    bus(1'b1, OFS_CRB, 32'h4321);
    bus(1'b1, OFS_CNT2, 32'h55);
    bus(1'b1, OFS_MCTRL, 32'h0);
    for (int i = 0; i < 4; i++) bus(1'b1, 6'(4 * i), 32'h99);
    rd(OFS_CNT1, "cnt1_gated", 32'haa);
    rd(OFS_CRA, "cra_gated", 32'h1234);
    rd(OFS_CRB, "crb_gated", 32'h4321);
    rd(OFS_CNT2, "cnt2_gated", 32'h55);
  endtask
  task automatic t_event_count();
    bus(1'b1, OFS_MCTRL, mc(MD_DUAL, 1'b1, 1'b1, 1'b0));
    bus(1'b1, OFS_CKC, 32'h3 << CK_C2_LO);
    bus(1'b1, OFS_CNT2, 32'h10);
    mft_pin_stub_i.pulse(1'b1);
    mft_pin_stub_i.pulse(1'b1);
    rd(OFS_CNT2, "event_count", 32'h0e);
    bus(1'b1, OFS_CKC, 32'h0);
  endtask
  task automatic t_capture_dual();
    bus(1'b1, OFS_MCTRL, mc(MD_CAP2, 1'b0, 1'b0, 1'b0));
    bus(1'b1, OFS_CNT1, 32'h100);
    mft_pin_stub_i.pulse(1'b0);
    rd(OFS_CRA, "cra_capture", 32'h100);
    rd(OFS_ICTRL, "pending_a", 32'h10);
    chk("irq_one_masked", 32'h0, 32'(irq_one));
    mft_pin_stub_i.pulse(1'b1);
    rd(OFS_CRB, "crb_capture", 32'h100);
    rd(OFS_ICTRL, "pending_ab", 32'h30);
    bus(1'b1, OFS_ICTRL, 32'h1);
    @(negedge core_clk);
    chk("irq_one_on", 32'h1, 32'(irq_one));
    chk("irq_two_off", 32'h0, 32'(irq_two));
    bus(1'b1, OFS_ICLR, 32'h3);
    rd(OFS_ICTRL, "pending_clear", 32'h1);
    rd(OFS_ICLR, "iclr_read", 32'h0);
    bus(1'b1, OFS_MCTRL, 32'h0);
    bus(1'b1, OFS_MCTRL, mc(MD_CAP2, 1'b1, 1'b0, 1'b0));
    bus(1'b1, OFS_CKC, 32'h1 << CK_C1_LO);
    bus(1'b1, OFS_CNT1, 32'h200);
    repeat (20) @(posedge core_clk);
    rd(OFS_CNT1, "cnt1_held", 32'h200);
    mft_pin_stub_i.pulse(1'b0);
    rd(OFS_CRA, "cra_preset", 32'h200);
    chk("cra_upper", 32'h0, q & 32'hffff0000);
    bus(1'b0, OFS_CNT1, 32'h0);
    chk("cnt1_preset", 32'h0000ff, {8'h0, q[31:8]});
    bus(1'b1, OFS_CKC, 32'h0);
    bus(1'b1, OFS_ICLR, 32'hf);
    bus(1'b1, OFS_ICTRL, 32'h0);
  endtask
  task automatic t_capture_timer2();
    bus(1'b1, OFS_MCTRL, mc(MD_CAPT, 1'b0, 1'b1, 1'b0));
    bus(1'b1, OFS_CNT2, 32'h77);
    mft_pin_stub_i.pulse(1'b1);
    rd(OFS_CRB, "crb_timer2", 32'h77);
    rd(OFS_CNT2, "cnt2_preset", 32'hffff);
    rd(OFS_ICTRL, "pending_b", 32'h20);
    bus(1'b1, OFS_ICLR, 32'hf);
  endtask
  task automatic t_waveform();
    int n = 0;
    bus(1'b1, OFS_MCTRL, mc(MD_PWM, 1'b1, 1'b0, 1'b1));
    @(negedge core_clk);
    chk("pin_start", 32'h1, 32'(pin_out));
    chk("pin_oe", 32'h1, 32'(pin_oe));
    for (int i = 0; i < 4; i++) bus(1'b1, 6'(4 * i), 32'h3);
    bus(1'b1, OFS_ICTRL, 32'h8);
    bus(1'b1, OFS_CKC, (32'h1 << CK_C1_LO) | (32'h1 << CK_C2_LO));
    while ((pin_out === 1'b1 || irq_two !== 1'b1) && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk("pin_toggle", 32'h0, 32'(pin_out));
    chk("irq_two_on", 32'h1, 32'(irq_two));
    bus(1'b1, OFS_CKC, 32'h0);
    bus(1'b0, OFS_ICTRL, 32'h0);
    chk("pending_ad", 32'h98, q & 32'h98);
    chk("irq_one_masked", 32'h0, 32'(irq_one));
    bus(1'b1, OFS_MCTRL, mc(MD_PWM, 1'b0, 1'b0, 1'b0));
    @(negedge core_clk);
    chk("pin_oe_off", 32'h0, 32'(pin_oe));
    lvl = pin_out;
    bus(1'b1, OFS_CKC, 32'h1 << CK_C1_LO);
    repeat (40) @(posedge core_clk);
    chk("pin_hold", 32'(lvl), 32'(pin_out));
    bus(1'b1, OFS_CKC, 32'h0);
    bus(1'b1, OFS_ICTRL, 32'h0);
  endtask

  initial begin
    rst_n = 1'b0;
    wb_req = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_map();
    t_write_gate();
    t_event_count();
    t_capture_dual();
    t_capture_timer2();
    t_waveform();
    results();
  end
endmodule
